/* logic/cpu_bus_cycle.sv */
// Internal bus cycle unit: memory/peripheral timing, splits, bit ops, block move
`timescale 1ns/1ps
module cpu_bus_cycle (
  input  wire logic                     clk,                        // System clock
  input  wire logic                     reset_n,                    // Async reset, low
  input  wire logic                     req,                        // Operation request
  input  wire cpu_bus_pkg::op_t         req_op,                     // Operation kind
  input  wire logic              [15:0] req_addr,                   // Target address
  input  wire logic                     req_word,                   // Word size
  input  wire logic              [15:0] req_wdata,                  // Write data
  input  wire logic               [2:0] bit_sel,                    // Bit number
  input  wire cpu_bus_pkg::bit_kind_t   bit_kind,                   // Bit operation
  input  wire logic                     bit_carry,                  // Value for stores
  input  wire logic               [7:0] block_byte_count_register,  // Move count
  input  wire logic              [15:0] block_source_pointer,       // Move source
  input  wire logic              [15:0] block_destination_pointer,  // Move destination
  input  wire logic                     halt_req,                   // Enter sleep/standby
  input  wire logic                     wake_req,                   // Leave halt
  input  wire logic                     exc_req,                    // Exception request
  input  wire logic              [15:0] mem_rdata,                  // Read data
  input  wire logic               [7:0] port_pin_in,                // Port pin levels
  output logic                          busy_r,                     // Operation running
  output logic                          done_r,                     // Operation done pulse
  output logic                   [15:0] rdata_r,                    // Read result
  output logic                   [15:0] mem_addr_r,                 // Bus address
  output logic                          mem_rd_r,                   // Read strobe
  output logic                          mem_wr_r,                   // Write strobe
  output logic                          mem_word_r,                 // Word cycle
  output logic                   [15:0] mem_wdata_r,                // Write data
  output cpu_bus_pkg::core_state_t      core_state_r,               // Core state
  output logic                    [7:0] port_out,                   // Port latch
  output logic                    [7:0] port_oe                     // Port drive enable
);
  import cpu_bus_pkg::*;

  //----------------------------------------------------------------------------
  // Decoding functions
  //----------------------------------------------------------------------------
  function automatic region_t region_of(input logic [15:0] a);
    if (a == PORT_LATCH_A || a == PORT_DIR_A) return RG_PORT;
    if (a >= P8_2_BASE)                       return RG_P8_2;
    if (a >= P8_3_BASE)                       return RG_P8_3;
    if (a >= RAM_BASE || a <= ROM_TOP)        return RG_MEM;
    if (a >= P16_BASE)                        return RG_P16;
    return RG_EMPTY;
  endfunction

  // Peripherals of the 8-bit path; port registers sit among them
  function automatic logic is_byte_path(input region_t rg);
    return rg == RG_P8_3 || rg == RG_P8_2 || rg == RG_PORT;
  endfunction

  function automatic logic [1:0] states_of(input region_t rg);
    return (rg == RG_P8_3) ? ST_THREE : ST_TWO;
  endfunction

  function automatic logic [7:0] bit_modify(input logic [7:0] b, input logic [2:0] s,
                                            input bit_kind_t k, input logic c);
    logic [7:0] m;
    m = 8'h01 << s;
    unique case (k)
      BK_SET:       return b | m;
      BK_CLEAR:     return b & ~m;
      BK_INVERT:    return b ^ m;
      BK_STORE:     return c ? (b | m) : (b & ~m);
      BK_STORE_INV: return c ? (b & ~m) : (b | m);
      default:      return b;
    endcase
  endfunction

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  seq_t        seq_r, seq_nxt;
  op_t         op_r, op_nxt;
  bit_kind_t   kind_r, kind_nxt;
  core_state_t cs_nxt;
  logic [1:0]  t_r, t_nxt;
  logic [15:0] addr_nxt, wdata_nxt, rdata_nxt, data_r, data_nxt, src_r, src_nxt, dst_r, dst_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [2:0]  sel_r, sel_nxt;
  logic        wr_r, wr_nxt, split_r, split_nxt, second_r, second_nxt, carry_r, carry_nxt;
  logic        rd_nxt, wrs_nxt, word_nxt, done_nxt, busy_nxt;
  logic        go, g_wr, g_word, cyc_end;
  logic [15:0] g_addr, g_wdata;
  logic [7:0]  rd_byte, port_rd;
  region_t     rg_cur;

  assign rg_cur  = region_of(mem_addr_r);
  assign cyc_end = (seq_r == S_BUS) && (t_r == states_of(rg_cur));
  assign rd_byte = (rg_cur == RG_PORT) ? port_rd : mem_rdata[7:0];

  //----------------------------------------------------------------------------
  // Operation sequencer and bus cycle timing
  //----------------------------------------------------------------------------
  // Next values of the sequencer and bus outputs
  always_comb begin
    seq_nxt = seq_r; op_nxt = op_r; kind_nxt = kind_r; t_nxt = t_r;
    addr_nxt = mem_addr_r; wdata_nxt = mem_wdata_r; rdata_nxt = rdata_r;
    data_nxt = data_r; src_nxt = src_r; dst_nxt = dst_r; cnt_nxt = cnt_r;
    sel_nxt = sel_r; wr_nxt = wr_r; split_nxt = split_r; second_nxt = second_r;
    carry_nxt = carry_r; rd_nxt = mem_rd_r; wrs_nxt = mem_wr_r; word_nxt = mem_word_r;
    done_nxt = 1'b0; busy_nxt = busy_r;
    go = 1'b0; g_wr = 1'b0; g_word = 1'b0; g_addr = mem_addr_r; g_wdata = mem_wdata_r;
    unique case (seq_r)
      S_IDLE: begin
        if (req && core_state_r == CS_EXEC) begin
          op_nxt = req_op; kind_nxt = bit_kind; sel_nxt = bit_sel; carry_nxt = bit_carry;
          second_nxt = 1'b0;
          split_nxt = req_word && is_byte_path(region_of(req_addr));
          data_nxt = req_wdata;
          busy_nxt = 1'b1;
          unique case (req_op)
            OP_READ, OP_WRITE: begin
              go = 1'b1; g_addr = req_addr; g_wr = (req_op == OP_WRITE);
              g_word = req_word && !is_byte_path(region_of(req_addr));
              g_wdata = (req_word && !g_word) ? {8'h00, req_wdata[15:8]} : req_wdata;
            end
            OP_BIT: begin
              go = 1'b1; g_addr = req_addr;
            end
            OP_MOVE: begin
              cnt_nxt = block_byte_count_register;
              src_nxt = block_source_pointer;
              dst_nxt = block_destination_pointer;
              if (block_byte_count_register == BYTE_RST) begin
                done_nxt = 1'b1; busy_nxt = 1'b0;
              end else begin
                go = 1'b1; g_addr = block_source_pointer;
              end
            end
          endcase
        end
      end
      S_BUS: begin
        if (!cyc_end) begin
          t_nxt = t_r + 2'h1;
        end else begin
          unique case (op_r)
            OP_READ: begin
              if (split_r && !second_r) begin
                data_nxt[15:8] = rd_byte; second_nxt = 1'b1;
                go = 1'b1; g_addr = mem_addr_r + 16'h0001;
              end else begin
                done_nxt = 1'b1;
                if (mem_word_r) rdata_nxt = mem_rdata;
                else if (second_r) rdata_nxt = {data_r[15:8], rd_byte};
                else rdata_nxt = {8'h00, rd_byte};
              end
            end
            OP_WRITE: begin
              if (split_r && !second_r) begin
                second_nxt = 1'b1; go = 1'b1; g_wr = 1'b1;
                g_addr = mem_addr_r + 16'h0001; g_wdata = {8'h00, data_r[7:0]};
              end else begin
                done_nxt = 1'b1;
              end
            end
            OP_BIT: begin
              if (!wr_r) begin
                go = 1'b1; g_wr = 1'b1; g_addr = mem_addr_r;
                g_wdata = {8'h00, bit_modify(rd_byte, sel_r, kind_r, carry_r)};
                rdata_nxt = {8'h00, rd_byte};
              end else begin
                done_nxt = 1'b1;
              end
            end
            OP_MOVE: begin
              if (!wr_r) begin
                go = 1'b1; g_wr = 1'b1; g_addr = dst_r; g_wdata = {8'h00, rd_byte};
              end else begin
                cnt_nxt = cnt_r - 8'h01; src_nxt = src_r + 16'h0001;
                dst_nxt = dst_r + 16'h0001; // no wrap guard, software keeps end in range
                if (cnt_r == 8'h01) begin
                  done_nxt = 1'b1;
                end else begin
                  go = 1'b1; g_addr = src_r + 16'h0001;
                end
              end
            end
          endcase
          if (done_nxt) busy_nxt = 1'b0;
        end
      end
    endcase
    // Launch a bus cycle; port and empty areas never strobe the outer bus
    if (go) begin
      seq_nxt = S_BUS; t_nxt = T_FIRST; addr_nxt = g_addr; wr_nxt = g_wr;
      word_nxt = g_word; wdata_nxt = g_wdata;
      rd_nxt  = !g_wr && region_of(g_addr) != RG_PORT && region_of(g_addr) != RG_EMPTY;
      wrs_nxt = g_wr && region_of(g_addr) != RG_PORT && region_of(g_addr) != RG_EMPTY;
    end else if (cyc_end) begin
      seq_nxt = S_IDLE; rd_nxt = 1'b0; wrs_nxt = 1'b0;
    end
  end

  // Register stage of the sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_r <= S_IDLE; op_r <= OP_READ; kind_r <= BK_SET; t_r <= T_FIRST;
      mem_addr_r <= WORD_RST; mem_wdata_r <= WORD_RST; rdata_r <= WORD_RST;
      data_r <= WORD_RST; src_r <= WORD_RST; dst_r <= WORD_RST; cnt_r <= BYTE_RST;
      sel_r <= 3'h0; wr_r <= 1'b0; split_r <= 1'b0; second_r <= 1'b0; carry_r <= 1'b0;
      mem_rd_r <= 1'b0; mem_wr_r <= 1'b0; mem_word_r <= 1'b0; done_r <= 1'b0; busy_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt; op_r <= op_nxt; kind_r <= kind_nxt; t_r <= t_nxt;
      mem_addr_r <= addr_nxt; mem_wdata_r <= wdata_nxt; rdata_r <= rdata_nxt;
      data_r <= data_nxt; src_r <= src_nxt; dst_r <= dst_nxt; cnt_r <= cnt_nxt;
      sel_r <= sel_nxt; wr_r <= wr_nxt; split_r <= split_nxt; second_r <= second_nxt;
      carry_r <= carry_nxt; mem_rd_r <= rd_nxt; mem_wr_r <= wrs_nxt; mem_word_r <= word_nxt;
      done_r <= done_nxt; busy_r <= busy_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Core state
  //----------------------------------------------------------------------------
  // Reset exception first, then execution; halt only between operations
  always_comb begin
    cs_nxt = core_state_r;
    unique case (core_state_r)
      CS_RESET:  cs_nxt = CS_EXCEPT;
      CS_EXCEPT: cs_nxt = CS_EXEC;
      CS_EXEC: begin
        if (exc_req && seq_r == S_IDLE && !req) cs_nxt = CS_EXCEPT;
        else if (halt_req && seq_r == S_IDLE && !req) cs_nxt = CS_HALT;
      end
      CS_HALT:   if (wake_req) cs_nxt = CS_EXCEPT;
    endcase
  end

  // Register stage of the core state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) core_state_r <= CS_RESET;
    else core_state_r <= cs_nxt;
  end

  //----------------------------------------------------------------------------
  // Port unit, written at the last state of a port write cycle
  //----------------------------------------------------------------------------
  port_unit u_port (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (cyc_end && wr_r && rg_cur == RG_PORT),
    .wr_dir  (mem_addr_r == PORT_DIR_A),
    .wdata   (mem_wdata_r[7:0]),
    .rd_dir  (mem_addr_r == PORT_DIR_A),
    .pin_in  (port_pin_in),
    .rd_data (port_rd),
    .pin_out (port_out),
    .pin_oe  (port_oe)
  );

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence two_states;
    (t_r == T_FIRST) ##1 (t_r == ST_TWO && cyc_end);
  endsequence
  sequence three_states;
    (t_r == T_FIRST) ##1 (t_r == ST_TWO && !cyc_end) ##1 (t_r == ST_THREE && cyc_end);
  endsequence

  a_state_range: assert property (
    seq_r == S_BUS |-> t_r >= T_FIRST && t_r <= ST_THREE)
    else $error("bus cycle state count out of range");
  a_mem_two_state: assert property (
    (seq_r == S_BUS && t_r == T_FIRST && rg_cur == RG_MEM) |-> two_states)
    else $error("memory cycle not two states");
  a_periph_three: assert property (
    (seq_r == S_BUS && t_r == T_FIRST && rg_cur == RG_P8_3) |-> three_states)
    else $error("slow peripheral cycle not three states");
  a_periph_two_same: assert property (
    (seq_r == S_BUS && t_r == T_FIRST && rg_cur == RG_P8_2) |-> two_states)
    else $error("two-state peripheral timing differs");
  a_word_split: assert property (
    (cyc_end && split_r && !second_r && op_r != OP_BIT) |=>
      seq_r == S_BUS && t_r == T_FIRST && second_r && mem_addr_r == $past(mem_addr_r) + 16'h0001)
    else $error("split word second cycle missing");
  a_empty_write: assert property (
    (seq_r == S_BUS && rg_cur == RG_EMPTY) |-> !mem_wr_r && !mem_rd_r)
    else $error("empty area strobed");
  a_move_finish: assert property (
    (cyc_end && op_r == OP_MOVE && wr_r && cnt_r == 8'h01) |=> done_r && cnt_r == BYTE_RST)
    else $error("block move did not finish on last byte");
  a_bit_rmw: assert property (
    (cyc_end && op_r == OP_BIT && !wr_r) |=>
      wr_r && !mem_word_r && t_r == T_FIRST && mem_addr_r == $past(mem_addr_r))
    else $error("bit write-back not to same address");
  a_core_reset_seq: assert property (
    core_state_r == CS_EXCEPT |=> core_state_r == CS_EXEC)
    else $error("exception state did not return to execution");

endmodule

/* logic/cpu_bus_pkg.sv */
// Constants, types and address map for the internal bus cycle unit
//------------------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------------------
package cpu_bus_pkg;

  //----------------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_BIT, OP_MOVE} op_t;
  typedef enum logic [2:0] {BK_SET, BK_CLEAR, BK_INVERT, BK_STORE, BK_STORE_INV} bit_kind_t;
  typedef enum logic [1:0] {CS_RESET, CS_EXEC, CS_HALT, CS_EXCEPT} core_state_t;
  typedef enum logic [2:0] {RG_MEM, RG_P16, RG_P8_3, RG_P8_2, RG_PORT, RG_EMPTY} region_t;
  typedef enum logic {S_IDLE, S_BUS} seq_t;

  //----------------------------------------------------------------------------
  // Address map
  //----------------------------------------------------------------------------
  localparam logic [15:0] ROM_TOP      = 16'h7fff;
  localparam logic [15:0] P16_BASE     = 16'hf700;
  localparam logic [15:0] RAM_BASE     = 16'hf780;
  localparam logic [15:0] P8_3_BASE    = 16'hff80;
  localparam logic [15:0] P8_2_BASE    = 16'hffc0;
  localparam logic [15:0] PORT_LATCH_A = 16'hffd8;
  localparam logic [15:0] PORT_DIR_A   = 16'hffe8;

  //----------------------------------------------------------------------------
  // Timing and reset values
  //----------------------------------------------------------------------------
  localparam logic [1:0]  T_FIRST      = 2'h1;
  localparam logic [1:0]  ST_TWO       = 2'h2;
  localparam logic [1:0]  ST_THREE     = 2'h3;
  localparam logic [7:0]  DIR_READBACK = 8'hff;
  localparam logic [7:0]  LATCH_RST    = 8'h00;
  localparam logic [7:0]  DIR_RST      = 8'h00;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;

endpackage

/* logic/port_unit.sv */
// Port output latch and direction register; output bits read back the latch, input bits the pins
`timescale 1ns/1ps
module port_unit (
  input  wire logic       clk,       // System clock
  input  wire logic       reset_n,   // Asynchronous reset, active low
  input  wire logic       wr_en,     // Write strobe, one cycle
  input  wire logic       wr_dir,    // Write targets direction register
  input  wire logic [7:0] wdata,     // Write byte
  input  wire logic       rd_dir,    // Read targets direction register
  input  wire logic [7:0] pin_in,    // Pin levels
  output logic      [7:0] rd_data,   // Read byte
  output logic      [7:0] pin_out,   // Output latch to pins
  output logic      [7:0] pin_oe     // Drive enable per pin
);
  import cpu_bus_pkg::*;

  logic [7:0] port_output_latch_r;
  logic [7:0] port_output_latch_nxt;
  logic [7:0] port_direction_control_r;
  logic [7:0] port_direction_control_nxt;

  //----------------------------------------------------------------------------
  // Register writes
  //----------------------------------------------------------------------------
  // Next values of latch and direction
  always_comb begin
    port_output_latch_nxt      = port_output_latch_r;
    port_direction_control_nxt = port_direction_control_r;
    if (wr_en && wr_dir) begin
      port_direction_control_nxt = wdata;
    end else if (wr_en) begin
      port_output_latch_nxt = wdata;
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_output_latch_r      <= LATCH_RST;
      port_direction_control_r <= DIR_RST;
    end else begin
      port_output_latch_r      <= port_output_latch_nxt;
      port_direction_control_r <= port_direction_control_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Readback and pins
  //----------------------------------------------------------------------------
  // Direction register is write-only; output bits read latch, inputs read pins
  always_comb begin
    if (rd_dir) begin
      rd_data = DIR_READBACK;
    end else begin
      rd_data = (port_direction_control_r & port_output_latch_r)
              | (~port_direction_control_r & pin_in);
    end
  end

  assign pin_out = port_output_latch_r;
  assign pin_oe  = port_direction_control_r;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_port_out_bits: assert property (
    (wr_en && !wr_dir && !rd_dir) ##1 !rd_dir |->
      ((rd_data & port_direction_control_r) == ($past(wdata, 1) & port_direction_control_r)))
    else $error("port read of output bits differs from latch");

  a_port_in_bits: assert property (
    !rd_dir |-> ((rd_data & ~pin_oe) == (pin_in & ~pin_oe)))
    else $error("port read of input bits differs from pins");

endmodule

/* bench/mem_model.sv */
// Behavioural on-chip memory and peripheral register model on the far side
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk,    // System clock
  input  wire logic [15:0] addr,   // Cycle address
  input  wire logic        rd,     // Read strobe
  input  wire logic        wr,     // Write strobe
  input  wire logic        word,   // Word cycle
  input  wire logic [15:0] wdata,  // Write data
  output logic      [15:0] rdata   // Read data
);
  logic [7:0]  mem [0:65535];
  logic [15:0] last;
  //----------------------------------------------------------------------------
  // Storage: word goes high byte to even address, byte on lane [7:0]
  //----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr && word) begin
      mem[{addr[15:1], 1'b0}] <= wdata[15:8];
      mem[{addr[15:1], 1'b1}] <= wdata[7:0];
    end else if (wr) begin
      mem[addr] <= wdata[7:0];
    end
    if (rd) begin
      last <= rdata;
    end
  end
  // Read lane; released bus shows the inverse of the last value
  always_comb begin
    if (rd && word) begin
      rdata = {mem[{addr[15:1], 1'b0}], mem[{addr[15:1], 1'b1}]};
    end else if (rd) begin
      rdata = {~last[15:8], mem[addr]};
    end else begin
      rdata = ~last;
    end
  end
endmodule

/* bench/tb.sv */
// Self-checking testbench for the internal bus cycle unit
`timescale 1ns/1ps
module tb;
  import cpu_bus_pkg::*;
  logic clk, reset_n, req, req_word, bit_carry, halt_req, wake_req, exc_req;
  logic busy_r, done_r, mem_rd_r, mem_wr_r, mem_word_r;
  op_t o_r;
  bit_kind_t bk;
  core_state_t cs;
  logic [2:0] bsel;
  logic [7:0] cnt, pins, pout, poe, v, exp_b;
  logic [15:0] adr, wd, src, dst, mrd, rdata_r, maddr, mwd, ta;
  int fail_count, cmp_count, empty_wr;
  cpu_bus_cycle uut (.clk(clk), .reset_n(reset_n), .req(req), .req_op(o_r), .req_addr(adr),
    .req_word(req_word), .req_wdata(wd), .bit_sel(bsel), .bit_kind(bk), .bit_carry(bit_carry),
    .block_byte_count_register(cnt), .block_source_pointer(src),
    .block_destination_pointer(dst), .halt_req(halt_req), .wake_req(wake_req),
    .exc_req(exc_req), .mem_rdata(mrd), .port_pin_in(pins), .busy_r(busy_r), .done_r(done_r),
    .rdata_r(rdata_r), .mem_addr_r(maddr), .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r),
    .mem_word_r(mem_word_r), .mem_wdata_r(mwd), .core_state_r(cs), .port_out(pout),
    .port_oe(poe));
  mem_model mdl (.clk(clk), .addr(maddr), .rd(mem_rd_r), .wr(mem_wr_r), .word(mem_word_r),
    .wdata(mwd), .rdata(mrd));
  //----------------------------------------------------------------------------
  // Clock, empty-area write-strobe monitor and watchdog
  //----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if ((mem_wr_r === 1'b1) && (maddr >= 16'h8000) && (maddr < P16_BASE)) empty_wr++;
  end
  initial begin
    #(20000 * 100);
    fail_count++;
    close_out();
  end
  //----------------------------------------------------------------------------
  // Helper tasks and expectation function
  //----------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, then the accept-to-done span is compared with the state count
  task automatic op(input op_t o, input logic [15:0] a, input logic w, input logic [15:0] d,
                    input int st);
    int k;
    k = 0;
    @(posedge clk);
    req <= 1'b1; o_r <= o; adr <= a; req_word <= w; wd <= d;
    @(posedge clk);
    req <= 1'b0;
    repeat (200) begin
      @(negedge clk);
      if (done_r === 1'b1) break;
      k++;
    end
    chk(16'(k), 16'(st));
  endtask
  task automatic wait_cs(input core_state_t s);
    repeat (20) begin
      @(negedge clk);
      if (cs === s) break;
    end
    chk({14'h0, cs}, {14'h0, s});
  endtask
  function automatic logic [7:0] bitf(logic [7:0] x, bit_kind_t k, logic [2:0] b, logic c);
    case (k)
      BK_SET:    x[b] = 1'b1;
      BK_CLEAR:  x[b] = 1'b0;
      BK_INVERT: x[b] = ~x[b];
      BK_STORE:  x[b] = c;
      default:   x[b] = ~c;
    endcase
    return x;
  endfunction
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial begin
    {reset_n, req, req_word, bit_carry, halt_req, wake_req, exc_req} = '0;
    o_r = OP_READ;
    bk = BK_SET;
    {bsel, cnt, pins, adr, wd, src, dst} = '0;
    {fail_count, cmp_count, empty_wr} = '0;
    void'($urandom(32'h38131d3f));
    repeat (16) @(posedge clk);
    chk({14'h0, cs}, {14'h0, CS_RESET});
    reset_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk({14'h0, cs}, {14'h0, CS_EXCEPT});
    @(negedge clk);
    chk({14'h0, cs}, {14'h0, CS_EXEC});
    ta = 16'($urandom());
    op(OP_WRITE, 16'hf900, 1'b1, ta, 2);
    op(OP_READ, 16'hf900, 1'b1, 16'h0, 2);
    chk(rdata_r, ta);
    op(OP_READ, 16'hf901, 1'b0, 16'h0, 2);
    chk(rdata_r, {8'h00, ta[7:0]});
    op(OP_READ, P16_BASE, 1'b1, 16'h0, 2);
    op(OP_WRITE, P8_3_BASE, 1'b1, 16'ha55a, 6);
    chk({mdl.mem[P8_3_BASE], mdl.mem[P8_3_BASE + 16'h1]}, 16'ha55a);
    mdl.mem[16'hffc4] = 8'h3c;
    mdl.mem[16'hffc5] = 8'hc3;
    op(OP_READ, 16'hffc4, 1'b1, 16'h0, 4);
    chk(rdata_r, 16'h3cc3);
    chk(maddr, 16'hffc5);
    op(OP_WRITE, 16'h9000, 1'b0, 16'h00ff, 2);
    chk(16'(empty_wr), 16'h0);
    for (int i = 0; i < 10; i++) begin
      v = 8'($urandom());
      ta = 16'hf800 + 16'($urandom_range(255));
      mdl.mem[ta] = v;
      @(posedge clk);
      bk <= bit_kind_t'(i % 5); bsel <= 3'($urandom()); bit_carry <= 1'($urandom());
      op(OP_BIT, ta, 1'b0, 16'h0, 4);
      chk({8'h00, mdl.mem[ta]}, {8'h00, bitf(v, bk, bsel, bit_carry)});
      chk(rdata_r, {8'h00, v});
    end
    @(posedge clk);
    pins <= 8'($urandom());
    op(OP_WRITE, PORT_LATCH_A, 1'b0, 16'h0080, 2);
    op(OP_WRITE, PORT_DIR_A, 1'b0, 16'h003f, 2);
    chk({8'h00, poe}, 16'h003f);
    op(OP_READ, PORT_DIR_A, 1'b0, 16'h0, 2);
    chk(rdata_r, {8'h00, DIR_READBACK});
    exp_b = (pins & 8'hc0) | 8'h01;
    @(posedge clk);
    bk <= BK_SET; bsel <= 3'h0;
    op(OP_BIT, PORT_LATCH_A, 1'b0, 16'h0, 4);
    chk({8'h00, pout}, {8'h00, exp_b});
    // Shadow copy in RAM, bit op on the copy, then whole byte to the latch
    op(OP_WRITE, 16'hfb00, 1'b0, 16'h0080, 2);
    op(OP_BIT, 16'hfb00, 1'b0, 16'h0, 4);
    op(OP_READ, 16'hfb00, 1'b0, 16'h0, 2);
    op(OP_WRITE, PORT_LATCH_A, 1'b0, rdata_r, 2);
    chk({8'h00, pout}, 16'h0081);
    for (int n = 0; n < 4; n++) begin
      @(posedge clk);
      cnt <= 8'(n * 3); src <= 16'hf800 + 16'($urandom_range(64)); dst <= 16'hfa00;
      @(negedge clk);
      for (int j = 0; j < 9; j++) mdl.mem[src + 16'(j)] = 8'($urandom());
      op(OP_MOVE, 16'h0, 1'b0, 16'h0, n * 12);
      for (int j = 0; j < n * 3; j++) chk(mdl.mem[dst + 16'(j)], mdl.mem[src + 16'(j)]);
    end
    @(posedge clk);
    halt_req <= 1'b1;
    wait_cs(CS_HALT);
    @(posedge clk);
    halt_req <= 1'b0;
    wake_req <= 1'b1;
    wait_cs(CS_EXCEPT);
    @(posedge clk);
    wake_req <= 1'b0;
    wait_cs(CS_EXEC);
    @(posedge clk);
    exc_req <= 1'b1;
    wait_cs(CS_EXCEPT);
    @(posedge clk);
    exc_req <= 1'b0;
    wait_cs(CS_EXEC);
    close_out();
  end
endmodule
